// [switch_ctrl_regs.svh]
`ifndef SWITCH_CTRL_REGS_SVH
`define SWITCH_CTRL_REGS_SVH

// Byte address of the positive-node switch control word
`define SWITCH_CTRL_OFFSET 32'h0000_2158
`define SWITCH_CTRL_RESET 32'h0000_0000

// Number of stored low bits; bits above read as zero
`define SWITCH_CTRL_STORED 15

// Field positions
`define SECOND_LOAD_SHORT_BIT 14
`define LOAD_SHORT_BIT 13
`define COUNTER_ELECTRODE_BIT 10
`define ANALOG_PORT3_BIT 8
`define DRIVE_ELECTRODE_BIT 7
`define SENSE_ELECTRODE_BIT 6
`define ANALOG_PORT2_BIT 5
`define REFERENCE_ELECTRODE_BIT 4
`define ANALOG_INPUT3_BIT 3
`define ANALOG_INPUT2_BIT 2
`define ANALOG_INPUT1_BIT 1
`define CALIBRATION_RESISTOR_BIT 0

`endif

// [switch_ctrl_pkg.sv]
package switch_ctrl_pkg;

  typedef logic [31:0] word_type;
  typedef logic [3:0] byte_sel_type;

  typedef enum logic {
    bus_idle,
    bus_answer
  } bus_state_type;

endpackage

// [wb_slave_port.sv]
module wb_slave_port #(
  parameter int ADDR_WIDTH = 32
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic hit,
  output logic wb_ack,
  output logic take,
  output logic commit
);
  import switch_ctrl_pkg::*;

  bus_state_type state_reg;
  bus_state_type state_next;
  logic ack_next;
  wire request = wb_cyc & wb_stb;

  always_comb begin
    state_next = state_reg;
    ack_next = 1'b0;
    case (state_reg)
      bus_idle: begin
        if (request) begin
          state_next = bus_answer;
          ack_next = 1'b1;
        end
      end
      bus_answer: begin
        state_next = bus_idle;
      end
      default: begin
        state_next = bus_idle;
      end
    endcase
  end

  // Request is taken while idle; a write lands on the edge that samples ack
  assign take = (state_reg == bus_idle) & request;
  assign commit = (state_reg == bus_answer) & request & wb_we & hit;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg <= bus_idle;
      wb_ack <= 1'b0;
    end else begin
      state_reg <= state_next;
      wb_ack <= ack_next;
    end
  end

endmodule // wb_slave_port

// [switch_bank.sv]
`include "switch_ctrl_regs.svh"

module switch_bank #(
  parameter int WIDTH = `SWITCH_CTRL_STORED
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic write_en,
  input wire switch_ctrl_pkg::byte_sel_type sel,
  input wire switch_ctrl_pkg::word_type wdata,
  output logic [WIDTH-1:0] bits
);
  import switch_ctrl_pkg::*;

  localparam word_type RESET_WORD = `SWITCH_CTRL_RESET;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      wire lane_write = write_en & sel[i / 8];
      always_ff @(posedge clk) begin
        if (!resetn) begin
          bits[i] <= RESET_WORD[i];
        end else if (lane_write) begin
          bits[i] <= wdata[i];
        end
      end
    end
  endgenerate

endmodule // switch_bank

// [excitation_positive_switch_control.sv]
// The Wishbone interface to the registers was chosen for this implementation.
`include "switch_ctrl_regs.svh"

// Overview of operation
// - Register decoded at byte 0x2158; every bit resets to zero, all switches open.
// - Each switch bit is read/write; 1 closes its switch, 0 opens it.
// - Bit 13 closes the load short switch from amplifier output to positive node.
// - Bit 10 ties the positive node to the counter electrode pin.
// - Bit 8 ties the positive node to the analog port 3 pin.
// - Bit 7 ties the positive node to the drive electrode pin.
// - Bit 6 ties the positive node to the sense electrode pin.
// - Bit 5 ties the positive node to the analog port 2 pin.
// - Bit 4 ties the positive node to the reference electrode pin.
// - Bit 3 ties the positive node to the analog input 3 pin.
// - Bit 2 ties the positive node to the analog input 2 pin.
// - Bit 1 ties the positive node to the analog input 1 pin.
// - Bit 0 ties the positive node to the first calibration resistor pin.
module excitation_positive_switch_control #(
  parameter int ADDR_WIDTH = 32
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_WIDTH-1:0] wb_adr_i,
  input wire switch_ctrl_pkg::byte_sel_type wb_sel_i,
  input wire switch_ctrl_pkg::word_type wb_dat_i,
  output switch_ctrl_pkg::word_type wb_dat_o,
  output logic wb_ack_o,
  output logic second_load_short_switch,
  output logic load_short_switch,
  output logic counter_electrode_switch,
  output logic analog_port3_switch,
  output logic drive_electrode_switch,
  output logic sense_electrode_switch,
  output logic analog_port2_switch,
  output logic reference_electrode_switch,
  output logic analog_input3_switch,
  output logic analog_input2_switch,
  output logic analog_input1_switch,
  output logic calibration_resistor_switch
);
  import switch_ctrl_pkg::*;

  localparam int STORED = `SWITCH_CTRL_STORED;
  localparam word_type OFFSET_WORD = `SWITCH_CTRL_OFFSET;
  localparam logic [ADDR_WIDTH-1:0] OFFSET = OFFSET_WORD[ADDR_WIDTH-1:0];

  logic take;
  logic commit;
  logic [STORED-1:0] bits;
  word_type dat_next;

  // Word-aligned decode; the low two address bits are ignored, wb_sel_i selects lanes
  wire hit = (wb_adr_i[ADDR_WIDTH-1:2] == OFFSET[ADDR_WIDTH-1:2]);

  // Upper bits read as zero; unmapped addresses answer with zero data
  wire [31:0] read_word = {{(32 - STORED){1'b0}}, bits};
  assign dat_next = hit ? read_word : 32'h0000_0000;

  wb_slave_port #(
    .ADDR_WIDTH(ADDR_WIDTH)
  ) u_port (
    .clk(clk),
    .resetn(resetn),
    .wb_cyc(wb_cyc_i),
    .wb_stb(wb_stb_i),
    .wb_we(wb_we_i),
    .hit(hit),
    .wb_ack(wb_ack_o),
    .take(take),
    .commit(commit)
  );

  // Only the low stored bits exist, so writes above them are dropped
  switch_bank #(
    .WIDTH(STORED)
  ) u_bank (
    .clk(clk),
    .resetn(resetn),
    .write_en(commit),
    .sel(wb_sel_i),
    .wdata(wb_dat_i),
    .bits(bits)
  );

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (take) begin
      wb_dat_o <= dat_next;
    end
  end

  // Switch gates come straight from the stored bits; 1 means closed
  assign second_load_short_switch = bits[`SECOND_LOAD_SHORT_BIT];
  assign load_short_switch = bits[`LOAD_SHORT_BIT];
  assign counter_electrode_switch = bits[`COUNTER_ELECTRODE_BIT];
  assign analog_port3_switch = bits[`ANALOG_PORT3_BIT];
  assign drive_electrode_switch = bits[`DRIVE_ELECTRODE_BIT];
  assign sense_electrode_switch = bits[`SENSE_ELECTRODE_BIT];
  assign analog_port2_switch = bits[`ANALOG_PORT2_BIT];
  assign reference_electrode_switch = bits[`REFERENCE_ELECTRODE_BIT];
  assign analog_input3_switch = bits[`ANALOG_INPUT3_BIT];
  assign analog_input2_switch = bits[`ANALOG_INPUT2_BIT];
  assign analog_input1_switch = bits[`ANALOG_INPUT1_BIT];
  assign calibration_resistor_switch = bits[`CALIBRATION_RESISTOR_BIT];

endmodule // excitation_positive_switch_control

// [epsc_checker.sv]
`include "switch_ctrl_regs.svh"
module epsc_checker #(
  parameter int ADDR_WIDTH = 32
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_WIDTH-1:0] wb_adr_i,
  input wire switch_ctrl_pkg::byte_sel_type wb_sel_i,
  input wire switch_ctrl_pkg::word_type wb_dat_i,
  input wire switch_ctrl_pkg::word_type wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic load_short_switch,
  input wire logic calibration_resistor_switch
);
  import switch_ctrl_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  localparam word_type OFF_WORD = `SWITCH_CTRL_OFFSET;
  wire hit = wb_adr_i[ADDR_WIDTH-1:2] == OFF_WORD[ADDR_WIDTH-1:2];
  wire rd_hit = wb_ack_o && !wb_we_i && hit;
  wire wr_hit = wb_ack_o && wb_we_i && hit;
  wire [1:0] sw = {load_short_switch, calibration_resistor_switch};
  chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
  chk_ack_due: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("stray ack");
  chk_miss_zero: assert property (wb_ack_o && !wb_we_i && !hit |-> wb_dat_o == '0)
    else $error("miss data");
  chk_top_zero: assert property (wb_ack_o |-> wb_dat_o[31:15] == '0)
    else $error("top bits");
  chk_read_map: assert property (rd_hit |-> {wb_dat_o[13], wb_dat_o[0]} == sw)
    else $error("read map");
  chk_load_write: assert property (wr_hit && wb_sel_i[1] |=> sw[1] == $past(wb_dat_i[13]))
    else $error("load bit");
  chk_cal_write: assert property (wr_hit && wb_sel_i[0] |=> sw[0] == $past(wb_dat_i[0]))
    else $error("cal bit");
  chk_sw_hold: assert property ($changed(sw) |-> $past(wr_hit) || !$past(resetn))
    else $error("sw moved");
  cover property (rd_hit);
  cover property (wr_hit && wb_sel_i == 4'hF);
  cover property (wb_ack_o && !hit);
endmodule // epsc_checker
bind excitation_positive_switch_control epsc_checker #(.ADDR_WIDTH(ADDR_WIDTH)) chk_u (
  .clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .load_short_switch, .calibration_resistor_switch);

// [tb.sv]
`include "switch_ctrl_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import switch_ctrl_pkg::*;
  localparam word_type A = `SWITCH_CTRL_OFFSET;
  logic clk = 0, resetn = 0, cyc = 0, we = 0, ack;
  word_type adr = '0, dat = '0, dat_o, got, v;
  byte_sel_type sel = '0;
  logic [11:0] sw;
  int miscompares = 0, comparisons = 0, cycles = 0;
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; $display("BAD %0t value mismatch", $time); end end
  always #2.5 clk = ~clk;
  excitation_positive_switch_control dut_u (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .second_load_short_switch(sw[11]),
    .load_short_switch(sw[10]), .counter_electrode_switch(sw[9]),
    .analog_port3_switch(sw[8]), .drive_electrode_switch(sw[7]),
    .sense_electrode_switch(sw[6]), .analog_port2_switch(sw[5]),
    .reference_electrode_switch(sw[4]), .analog_input3_switch(sw[3]),
    .analog_input2_switch(sw[2]), .analog_input1_switch(sw[1]),
    .calibration_resistor_switch(sw[0]));
  task automatic finish_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic xfer(logic w, word_type a, byte_sel_type s, word_type d);
    @(posedge clk);
    cyc <= 1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    got = dat_o;
    cyc <= 0;
  endtask
  task automatic rd(word_type a, word_type e, word_type r);
    xfer(0, a, '0, '0);
    `CHK(got, e)
    `CHK(sw, {r[14:13], r[10], r[8:0]})
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      miscompares++;
      finish_test;
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1;
    rd(A, '0, '0);
    $display("reset value done");
    for (int i = 0; i < 32; i++) begin
      v = 32'h1 << i & 32'h7FFF;
      xfer(1, A, 4'hF, 32'h1 << i);
      rd(A, v, v);
    end
    $display("walk done");
    xfer(1, A, 4'hF, '1);
    xfer(1, A, 4'h1, '0);
    rd(A + 3, 32'h7F00, 32'h7F00);
    xfer(1, A + 4, 4'hF, '0);
    rd(A + 4, '0, 32'h7F00);
    $display("lane done");
    xfer(0, A, '0, '0);
    xfer(1, A, 4'hF, (got | 32'h0000_0001) & 32'h0000_7FFF);
    rd(A, 32'h0000_7F01, 32'h0000_7F01);
    $display("modify done");
    resetn <= 0;
    @(posedge clk);
    resetn <= 1;
    rd(A, '0, '0);
    $display("reset done");
    finish_test;
  end
endmodule // tb
